/* hdl/lfbp_core.sv */
// lfbp_core: legacy data-link byte port, APB register file,
// match compare, sticky status and interrupt.
// assumes: framer strobes arrive on clk from on-chip logic;
// APB master holds each request until pready.
//
// Overview of operation
// - match on either code sets match flag
// - send byte in data-link or Fs positions
// - serialise written byte lsb first
// - set tx-empty after eight bits sent
// - tx-empty flag drives enabled interrupt low
// - unrefreshed byte is sent again
// - stuff zero after five ones when enabled
// - source select low takes Fs from byte
// - multiframe-load loads byte only on boundaries
// - Fs message fields via rx/tx byte registers
// - pack received bits, flag full, interrupt
// - remove zero after exactly five ones
// - keep zero after six or more ones
`timescale 1ns/1ps
module lfbp_core (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_bit_valid,
    input wire logic rx_bit,
    input wire logic tx_slot,
    input wire logic tx_mf_start,
    output logic tx_bit,
    output logic tx_fs_from_byte,
    output logic irq_n
);
    lfbp_link_if lk();

    logic [7:0] match_a_q;
    logic [7:0] match_b_q;
    logic [7:0] tx_byte_q;
    logic [7:0] ctrl_q;
    logic [7:0] irq_en_q;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_n_q;
    logic fs_byte_q;
    logic tx_bit_w;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    wire [9:0] idx;
    wire setup_acc;
    wire wr_acc;
    wire hit_rxb;
    wire hit_ma;
    wire hit_mb;
    wire hit_txb;
    wire hit_st;
    wire hit_en;
    wire hit_clr;
    wire hit_ct;
    wire mapped;
    wire [7:0] rd_byte;
    wire [7:0] clr_bits;
    wire [7:0] set_bits;
    wire match_hit;

    // one wait state: data is registered on the same edge that raises pready
    assign idx = paddr[11:2];
    assign setup_acc = psel && penable && !pready_q;
    assign wr_acc = psel && penable && pready_q && pwrite
        && !pslverr_q;
    assign hit_rxb = idx == lfbp_pkg::IDX_RX_BYTE;
    assign hit_ma = idx == lfbp_pkg::IDX_MATCH_A;
    assign hit_mb = idx == lfbp_pkg::IDX_MATCH_B;
    assign hit_txb = idx == lfbp_pkg::IDX_TX_BYTE;
    assign hit_st = idx == lfbp_pkg::IDX_STATUS;
    assign hit_en = idx == lfbp_pkg::IDX_IRQ_EN;
    assign hit_clr = idx == lfbp_pkg::IDX_IRQ_CLR;
    assign hit_ct = idx == lfbp_pkg::IDX_CTRL;
    assign mapped = hit_rxb || hit_ma || hit_mb || hit_txb
        || hit_st || hit_en || hit_clr || hit_ct;

    // read mux; write-only clear register reads zero
    assign rd_byte = hit_rxb ? lk.rx_byte :
        hit_ma ? match_a_q :
        hit_mb ? match_b_q :
        hit_txb ? tx_byte_q :
        hit_st ? status_q :
        hit_en ? irq_en_q :
        hit_ct ? ctrl_q : 8'h00;

    // ----------------------------------------
    // APB response
    // ----------------------------------------
    // pready pulses one cycle; bad address answers with pslverr
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setup_acc;
            pslverr_q <= setup_acc && !mapped;
            if (setup_acc) begin
                prdata_q <= {24'h00_0000, rd_byte};
            end
        end
    end

    // ----------------------------------------
    // writable registers
    // ----------------------------------------
    // read-only and clear registers ignore writes here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            match_a_q <= lfbp_pkg::RST_BYTE;
            match_b_q <= lfbp_pkg::RST_BYTE;
            tx_byte_q <= lfbp_pkg::RST_BYTE;
            ctrl_q <= lfbp_pkg::RST_CTRL;
            irq_en_q <= lfbp_pkg::RST_FLAGS;
        end else if (wr_acc) begin
            if (hit_ma) begin
                match_a_q <= pwdata[7:0];
            end
            if (hit_mb) begin
                match_b_q <= pwdata[7:0];
            end
            if (hit_txb) begin
                tx_byte_q <= pwdata[7:0];
            end
            if (hit_ct) begin
                ctrl_q <= pwdata[7:0];
            end
            if (hit_en) begin
                irq_en_q <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------
    // settings to the bit engines
    // ----------------------------------------
    assign lk.zc_en = ctrl_q[lfbp_pkg::CT_ZERO_CTL];
    assign lk.stuff_en = ctrl_q[lfbp_pkg::CT_STUFF];
    assign lk.mf_load = ctrl_q[lfbp_pkg::CT_MF_LOAD];
    assign lk.tx_hold = tx_byte_q;

    // ----------------------------------------
    // sticky status
    // ----------------------------------------
    // rx_byte is already registered when rx_done pulses
    assign match_hit = lk.rx_byte == match_a_q
        || lk.rx_byte == match_b_q;
    assign set_bits = {3'h0,
        lk.rx_done,
        lk.tx_done,
        lk.rx_done && match_hit,
        2'h0};
    assign clr_bits = (wr_acc && hit_clr) ? pwdata[7:0] : 8'h00;
    // a set in the clearing cycle wins, so no event is lost
    assign status_d = set_bits | (status_q & ~clr_bits);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= lfbp_pkg::RST_FLAGS;
        end else begin
            status_q <= status_d;
        end
    end

    // ----------------------------------------
    // interrupt and framer-side outputs
    // ----------------------------------------
    // level output, one cycle behind the flags it reflects
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_n_q <= 1'b1;
            fs_byte_q <= 1'b0;
        end else begin
            irq_n_q <= !(|(status_q & irq_en_q));
            fs_byte_q <= !ctrl_q[lfbp_pkg::CT_FS_SRC];
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq_n = irq_n_q;
    assign tx_fs_from_byte = fs_byte_q;
    assign tx_bit = tx_bit_w;

    // ----------------------------------------
    // bit engines
    // ----------------------------------------
    lfbp_rx_deframer u_rx (
        .clk(clk),
        .rst_n(rst_n),
        .bit_valid(rx_bit_valid),
        .bit_in(rx_bit),
        .lk(lk.rx)
    );

    lfbp_tx_serialiser u_tx (
        .clk(clk),
        .rst_n(rst_n),
        .slot(tx_slot),
        .mf_start(tx_mf_start),
        .bit_out(tx_bit_w),
        .lk(lk.tx)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_match_flag: assert property (
        lk.rx_done && match_hit |=> status_q[lfbp_pkg::ST_MATCH])
        else $error("match did not set its flag");
    a_empty_flag: assert property (
        lk.tx_done |=> status_q[lfbp_pkg::ST_TX_EMPTY])
        else $error("sent byte did not set empty flag");
    a_empty_irq: assert property (
        status_q[lfbp_pkg::ST_TX_EMPTY]
        && irq_en_q[lfbp_pkg::ST_TX_EMPTY] |=> !irq_n)
        else $error("empty flag did not pull interrupt low");
    a_full_irq: assert property (
        lk.rx_done && irq_en_q[lfbp_pkg::ST_RX_FULL]
        |=> ##1 !irq_n)
        else $error("full byte did not interrupt");
    a_ready_pulse: assert property (
        setup_acc |=> pready && !$past(pready) ##1 !pready)
        else $error("pready not a single pulse");
    a_fs_select: assert property (
        !ctrl_q[lfbp_pkg::CT_FS_SRC] |=> tx_fs_from_byte)
        else $error("Fs source not taken from byte");
endmodule

/* hdl/lfbp_link_if.sv */
// lfbp_link_if: settings and events between the register core
// and the receive and transmit bit engines.
// assumes: all three modules share one clock.
`timescale 1ns/1ps
interface lfbp_link_if;
    logic zc_en;
    logic stuff_en;
    logic mf_load;
    logic [7:0] tx_hold;
    logic [7:0] rx_byte;
    logic rx_done;
    logic tx_done;
    modport core(output zc_en, stuff_en, mf_load, tx_hold,
        input rx_byte, rx_done, tx_done);
    modport rx(input zc_en, output rx_byte, rx_done);
    modport tx(input stuff_en, mf_load, tx_hold, output tx_done);
endinterface

/* hdl/lfbp_pkg.sv */
// lfbp_pkg: register indices, field positions and reset values
// of the legacy data-link byte port.
// assumes: APB word addressing, byte address = 4 * index.
package lfbp_pkg;
    // ----------------------------------------
    // register indices (byte address = 4 * index)
    // ----------------------------------------
    localparam logic [9:0] IDX_RX_BYTE = 10'h028;
    localparam logic [9:0] IDX_MATCH_A = 10'h029;
    localparam logic [9:0] IDX_MATCH_B = 10'h02a;
    localparam logic [9:0] IDX_TX_BYTE = 10'h07e;
    localparam logic [9:0] IDX_STATUS = 10'h080;
    localparam logic [9:0] IDX_IRQ_EN = 10'h081;
    localparam logic [9:0] IDX_IRQ_CLR = 10'h082;
    localparam logic [9:0] IDX_CTRL = 10'h083;
    // ----------------------------------------
    // status, enable and clear bit positions
    // ----------------------------------------
    localparam int ST_MATCH = 2;
    localparam int ST_TX_EMPTY = 3;
    localparam int ST_RX_FULL = 4;
    // ----------------------------------------
    // control bit positions
    // ----------------------------------------
    localparam int CT_ZERO_CTL = 0;
    localparam int CT_FS_SRC = 2;
    localparam int CT_STUFF = 4;
    localparam int CT_MF_LOAD = 5;
    // ----------------------------------------
    // reset values and run length
    // ----------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [2:0] ONES_RUN = 3'h5;
    localparam logic [2:0] ONES_SAT = 3'h6;
endpackage

/* hdl/lfbp_rx_deframer.sv */
// lfbp_rx_deframer: destuffs received data-link bits and
// packs them lsb first into bytes.
// assumes: bit_valid is a one-cycle strobe from framer logic
// on the same clock, one per data-link or Fs position.
`timescale 1ns/1ps
module lfbp_rx_deframer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bit_valid,
    input wire logic bit_in,
    lfbp_link_if.rx lk
);
    logic [2:0] ones_q;
    logic [2:0] ones_d;
    logic [2:0] cnt_q;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [7:0] byte_q;
    logic done_q;
    wire drop;
    wire take;

    // ----------------------------------------
    // destuffing
    // ----------------------------------------
    // saturating at six tells a run of six apart from five
    assign drop = lk.zc_en && ones_q == lfbp_pkg::ONES_RUN
        && !bit_in;
    assign take = bit_valid && !drop;
    assign ones_d = !bit_in ? 3'h0 :
        (ones_q == lfbp_pkg::ONES_SAT) ? ones_q : ones_q + 3'h1;
    assign shift_d = {bit_in, shift_q[7:1]};

    // run counter follows every received bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ones_q <= 3'h0;
        end else if (bit_valid) begin
            ones_q <= ones_d;
        end
    end

    // ----------------------------------------
    // byte assembly
    // ----------------------------------------
    // the byte register only changes when eight bits are in
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= lfbp_pkg::RST_BYTE;
            cnt_q <= 3'h0;
            byte_q <= lfbp_pkg::RST_BYTE;
            done_q <= 1'b0;
        end else begin
            done_q <= take && cnt_q == 3'h7;
            if (take) begin
                shift_q <= shift_d;
                cnt_q <= cnt_q + 3'h1;
                if (cnt_q == 3'h7) begin
                    byte_q <= shift_d;
                end
            end
        end
    end

    assign lk.rx_byte = byte_q;
    assign lk.rx_done = done_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_destuff_drop: assert property (
        bit_valid && lk.zc_en && ones_q == 3'h5 && !bit_in
        |=> $stable(cnt_q) && !done_q)
        else $error("stuffed zero was not removed");
    a_six_keep: assert property (
        bit_valid && ones_q == 3'h6 && !bit_in
        |=> cnt_q == $past(cnt_q) + 3'h1)
        else $error("zero after six ones was removed");
endmodule

/* hdl/lfbp_tx_serialiser.sv */
// lfbp_tx_serialiser: sends the held transmit byte lsb first,
// one bit per slot strobe, with optional zero stuffing.
// assumes: slot and mf_start are one-cycle strobes from framer
// logic on the same clock.
`timescale 1ns/1ps
module lfbp_tx_serialiser (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slot,
    input wire logic mf_start,
    output logic bit_out,
    lfbp_link_if.tx lk
);
    logic [7:0] shift_q;
    logic [2:0] idx_q;
    logic [2:0] ones_q;
    logic mf_pend_q;
    logic bit_q;
    logic done_q;
    wire stuff;
    wire cap;
    wire send;
    wire [7:0] cur;

    // ----------------------------------------
    // slot decode
    // ----------------------------------------
    assign stuff = lk.stuff_en
        && ones_q == lfbp_pkg::ONES_RUN;
    // capture only at byte start so a late write never tears a byte
    assign cap = idx_q == 3'h0
        && (!lk.mf_load || mf_pend_q);
    // without a capture the rotated copy repeats the old byte
    assign cur = cap ? lk.tx_hold : shift_q;
    assign send = slot && !stuff;

    // multiframe boundary pending; a new boundary wins over use
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mf_pend_q <= 1'b0;
        end else begin
            mf_pend_q <= mf_start || (mf_pend_q && !(send && cap));
        end
    end

    // ----------------------------------------
    // bit engine
    // ----------------------------------------
    // rotate rather than shift so the byte survives for a resend
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= lfbp_pkg::RST_BYTE;
            idx_q <= 3'h0;
            ones_q <= 3'h0;
            bit_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= send && idx_q == 3'h7;
            if (slot && stuff) begin
                bit_q <= 1'b0;
                ones_q <= 3'h0;
            end else if (send) begin
                bit_q <= cur[0];
                shift_q <= {cur[0], cur[7:1]};
                idx_q <= idx_q + 3'h1;
                // saturate at five so a long unstuffed run holds at five and never wraps to zero
                ones_q <= !cur[0] ? 3'h0 :
                    (ones_q == lfbp_pkg::ONES_RUN) ? ones_q
                    : ones_q + 3'h1;
            end
        end
    end

    assign bit_out = bit_q;
    assign lk.tx_done = done_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_five_ones;
        slot && lk.stuff_en && ones_q == 3'h5;
    endsequence
    a_stuff_zero: assert property (
        s_five_ones |=> !bit_out && ones_q == 3'h0)
        else $error("no zero inserted after five ones");
    a_lsb_first: assert property (
        send && cap |=> bit_out == $past(lk.tx_hold[0]))
        else $error("byte did not start with its lsb");
    a_mf_hold: assert property (
        send && idx_q == 3'h0 && lk.mf_load && !mf_pend_q
        |=> bit_out == $past(shift_q[0]))
        else $error("byte loaded off a multiframe boundary");
endmodule

/* tb/legacy_fdl_byte_port_bench.sv */
// legacy_fdl_byte_port_bench: apb register tests, receive match
// and destuffing, transmit order, repeat, stuffing and loading.
// assumes: lfbp_core top, framer model drives the bit side.
`timescale 1ns/1ps
module legacy_fdl_byte_port_bench;
    // ----------------------------------------
    // signals and counters
    // ----------------------------------------
    localparam logic [7:0] M_MT = 8'h01 << lfbp_pkg::ST_MATCH;
    localparam logic [7:0] M_TE = 8'h01 << lfbp_pkg::ST_TX_EMPTY;
    localparam logic [7:0] M_RF = 8'h01 << lfbp_pkg::ST_RX_FULL;
    localparam logic [7:0] C_ZC = 8'h01 << lfbp_pkg::CT_ZERO_CTL;
    localparam logic [7:0] C_FS = 8'h01 << lfbp_pkg::CT_FS_SRC;
    localparam logic [7:0] C_ST = 8'h01 << lfbp_pkg::CT_STUFF;
    localparam logic [7:0] C_MF = 8'h01 << lfbp_pkg::CT_MF_LOAD;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic rx_bit_valid, rx_bit, tx_slot, tx_mf_start;
    logic tx_bit, tx_fs_from_byte, irq_n;
    logic [31:0] d;
    logic e;
    logic [15:0] g;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;

    // 25 ns period
    always #12.5 clk = ~clk;

    lfbp_core u_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_bit_valid(rx_bit_valid),
        .rx_bit(rx_bit), .tx_slot(tx_slot), .tx_mf_start(tx_mf_start),
        .tx_bit(tx_bit), .tx_fs_from_byte(tx_fs_from_byte),
        .irq_n(irq_n));
    lfbp_framer_model u_frm (.clk(clk), .rx_bit_valid(rx_bit_valid),
        .rx_bit(rx_bit), .tx_slot(tx_slot), .tx_mf_start(tx_mf_start),
        .tx_bit(tx_bit));

    // ----------------------------------------
    // report, compare and bus tasks
    // ----------------------------------------
    task end_sim;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // runs well past the few hundred cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count = fail_count + 1;
            end_sim();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // setup, access, wait for pready, then release
    task automatic xfer(input logic wr, input logic [9:0] i,
        input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {i, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
        end
        if (n == 50) chk(32'h0, 32'h1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [9:0] i, input logic [7:0] v);
        xfer(1'b1, i, {24'h0, v});
    endtask

    task rd(input logic [9:0] i);
        xfer(1'b0, i, 32'h0);
    endtask

    // read status and irq level, then clear every flag
    task flags(input logic [7:0] st, input logic irq);
        repeat (4) @(posedge clk);
        rd(lfbp_pkg::IDX_STATUS);
        chk(d, {24'h0, st});
        chk({31'h0, irq_n}, {31'h0, irq});
        wr(lfbp_pkg::IDX_IRQ_CLR, 8'h1c);
        rd(lfbp_pkg::IDX_STATUS);
        chk(d, 32'h0);
        chk({31'h0, irq_n}, 32'h1);
    endtask

    task rx(input logic [15:0] b, input int n, input int gap,
        input logic [7:0] exp);
        u_frm.send_rx(b, n, gap);
        repeat (4) @(posedge clk);
        rd(lfbp_pkg::IDX_RX_BYTE);
        chk(d, {24'h0, exp});
    endtask

    task tx(input int n, input int gap, input logic [15:0] exp);
        u_frm.run_tx(n, gap, g);
        chk({16'h0, g}, {16'h0, exp});
    endtask

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        logic [9:0] idx [7];
        idx = '{lfbp_pkg::IDX_RX_BYTE, lfbp_pkg::IDX_MATCH_A,
            lfbp_pkg::IDX_MATCH_B, lfbp_pkg::IDX_TX_BYTE,
            lfbp_pkg::IDX_STATUS, lfbp_pkg::IDX_IRQ_EN,
            lfbp_pkg::IDX_CTRL};
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        // reset values, then an unmapped word
        foreach (idx[k]) begin
            rd(idx[k]);
            chk(d, 32'h0);
        end
        rd(10'h3ff);
        chk({31'h0, e}, 32'h1);
        chk(d, 32'h0);
        chk({31'h0, tx_fs_from_byte}, 32'h1);
        $display("test registers_reset done");
        // match codes and a read-only status
        wr(lfbp_pkg::IDX_MATCH_A, 8'h5a);
        wr(lfbp_pkg::IDX_MATCH_B, 8'hc3);
        wr(lfbp_pkg::IDX_STATUS, 8'h1c);
        rd(lfbp_pkg::IDX_MATCH_A);
        chk(d, 32'h5a);
        rd(lfbp_pkg::IDX_MATCH_B);
        chk(d, 32'hc3);
        rd(lfbp_pkg::IDX_STATUS);
        chk(d, 32'h0);
        $display("test registers_rw done");
        // receive with both match codes, a miss and a masked flag
        wr(lfbp_pkg::IDX_IRQ_EN, M_MT | M_RF);
        rx(16'h005a, 8, 0, 8'h5a);
        flags(M_MT | M_RF, 1'b0);
        rx(16'h003c, 8, 3, 8'h3c);
        flags(M_RF, 1'b0);
        rx(16'h00c3, 8, 1, 8'hc3);
        flags(M_MT | M_RF, 1'b0);
        wr(lfbp_pkg::IDX_IRQ_EN, M_MT);
        rx(16'h003c, 8, 0, 8'h3c);
        flags(M_RF, 1'b1);
        $display("test rx_match done");
        // destuffing: zero after five ones goes, after six stays
        wr(lfbp_pkg::IDX_CTRL, C_ZC);
        rx(16'h001f, 9, 0, 8'h1f);
        rx(16'h003f, 8, 2, 8'h3f);
        wr(lfbp_pkg::IDX_IRQ_CLR, 8'h1c);
        $display("test rx_destuff done");
        // transmit lsb first, repeat, mid-byte write
        wr(lfbp_pkg::IDX_IRQ_EN, 8'h1c);
        wr(lfbp_pkg::IDX_TX_BYTE, 8'ha5);
        tx(8, 2, 16'h00a5);
        flags(M_TE, 1'b0);
        tx(4, 0, 16'h0005);
        wr(lfbp_pkg::IDX_TX_BYTE, 8'h3c);
        tx(4, 5, 16'h000a);
        tx(8, 0, 16'h003c);
        flags(M_TE, 1'b0);
        $display("test tx_serial done");
        // zero stuffing after five ones
        wr(lfbp_pkg::IDX_CTRL, C_ZC | C_ST);
        wr(lfbp_pkg::IDX_TX_BYTE, 8'hff);
        tx(9, 1, 16'h01df);
        flags(M_TE, 1'b0);
        $display("test tx_stuff done");
        // fs source select and multiframe loading
        wr(lfbp_pkg::IDX_CTRL, C_ZC | C_MF | C_FS);
        repeat (2) @(posedge clk);
        chk({31'h0, tx_fs_from_byte}, 32'h0);
        wr(lfbp_pkg::IDX_CTRL, C_ZC | C_MF);
        repeat (2) @(posedge clk);
        chk({31'h0, tx_fs_from_byte}, 32'h1);
        wr(lfbp_pkg::IDX_TX_BYTE, 8'h1c);
        tx(8, 1, 16'h00ff);
        u_frm.mf_pulse();
        tx(8, 1, 16'h001c);
        rd(lfbp_pkg::IDX_TX_BYTE);
        chk(d, 32'h1c);
        $display("test tx_multiframe done");
        end_sim();
    end
endmodule

/* tb/lfbp_framer_model.sv */
// lfbp_framer_model: framer-side stand-in that strobes received
// data-link bits in and takes transmit bits out of the port.
// assumes: same clock as the port, strobes one cycle wide.
`timescale 1ns/1ps
module lfbp_framer_model (
    input wire logic clk,
    output logic rx_bit_valid,
    output logic rx_bit,
    output logic tx_slot,
    output logic tx_mf_start,
    input wire logic tx_bit
);
    // ----------------------------------------
    // idle levels
    // ----------------------------------------
    // strobes rest low; the data line is not left at its last value
    initial begin
        rx_bit_valid = 1'b0;
        rx_bit = 1'b0;
        tx_slot = 1'b0;
        tx_mf_start = 1'b0;
    end

    // ----------------------------------------
    // receive bits, first bit is the lsb
    // ----------------------------------------
    // gap sets how slowly positions arrive; 0 gives one strobe every second cycle
    task automatic send_rx(input logic [15:0] bits, input int n,
        input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            rx_bit_valid <= 1'b1;
            rx_bit <= bits[i];
            @(posedge clk);
            rx_bit_valid <= 1'b0;
            rx_bit <= ~bits[i]; // released line shows no stale bit
            repeat (gap) @(posedge clk);
        end
    endtask

    // ----------------------------------------
    // transmit slots, bit taken after each slot strobe
    // ----------------------------------------
    task automatic run_tx(input int n, input int gap,
        output logic [15:0] got);
        got = '0;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            tx_slot <= 1'b1;
            @(posedge clk);
            tx_slot <= 1'b0;
            repeat (gap) @(posedge clk);
            // the edge that takes the slot launches the bit; read later
            @(negedge clk);
            got[i] = tx_bit; // bit holds until the next slot
        end
    endtask

    // one multiframe boundary strobe
    task automatic mf_pulse;
        @(posedge clk);
        tx_mf_start <= 1'b1;
        @(posedge clk);
        tx_mf_start <= 1'b0;
    endtask
endmodule
